// [rtl/ecl_pkg.sv]
// Constants shared by the serial configuration loader and its image memory
package ecl_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_NS = 20;
  localparam int SK_HALF_NS = 80;
  localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int POLL_MS = 10;
  localparam int POLL_CYCLES_DEF = (POLL_MS * 1000000) / CLK_NS;

  // ==========================================================================
  // Widths
  localparam int EE_AW = 9;
  localparam int IMG_AW = 6;
  localparam int CMD_W = 20;
  localparam logic [4:0] BITS_LONG = 5'h14;
  localparam logic [4:0] BITS_SHORT = 5'h0c;

  // ==========================================================================
  // Serial memory layout
  localparam logic [5:0] EA_SIG = 6'h00;
  localparam logic [5:0] EA_MAC_FIRST = 6'h01;
  localparam logic [5:0] EA_MAC_LAST = 6'h06;
  localparam logic [5:0] EA_FS = 6'h07;
  localparam logic [5:0] EA_HS = 6'h08;
  localparam logic [5:0] EA_FLAGS = 6'h09;
  localparam logic [5:0] EA_LANG_LO = 6'h0a;
  localparam logic [5:0] EA_LANG_HI = 6'h0b;
  localparam logic [5:0] EA_STR_FIRST = 6'h0c;
  localparam logic [5:0] EA_STR_LAST = 6'h15;
  localparam logic [5:0] EA_DESC_LAST = 6'h1d;
  localparam logic [5:0] EA_HS_CFG_LEN = 6'h18;
  localparam logic [5:0] EA_HS_CFG_OFF = 6'h19;
  localparam logic [5:0] EA_WAKE_LO = 6'h1e;
  localparam logic [5:0] EA_WAKE_HI = 6'h1f;
  localparam logic [5:0] EA_PME = 6'h20;
  localparam logic [7:0] SIG_VALID = 8'ha5;

  // ==========================================================================
  // Flag and attribute fields
  localparam int FLG_PWR = 0;
  localparam int FLG_LED = 1;
  localparam int FLG_RWK = 2;
  localparam int FLG_BOOST = 4;
  localparam logic [8:0] ATTR_OFS = 9'h007;
  localparam int ATTR_SELF = 6;
  localparam int ATTR_RWK = 5;
  localparam logic [7:0] DEV_DESC_TYPE = 8'h01;
  localparam logic [7:0] DEV_DESC_SIZE = 8'h12;
  localparam logic [7:0] CFG_DESC_TYPE = 8'h02;

  // ==========================================================================
  // Serial opcodes and host operations
  localparam logic [2:0] OPC_READ = 3'h6;
  localparam logic [2:0] OPC_WRITE = 3'h5;
  localparam logic [2:0] OPC_ERASE = 3'h7;
  localparam logic [2:0] OPC_EWEN = 3'h4;
  localparam logic [8:0] EWEN_ADDR = 9'h180;
  localparam logic [1:0] HOP_READ = 2'h0;
  localparam logic [1:0] HOP_WRITE = 2'h1;
  localparam logic [1:0] HOP_ERASE = 2'h2;
  localparam logic [1:0] HOP_EWEN = 2'h3;

  // ==========================================================================
  // Register map (byte addresses) and control bits
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_CMD_ADDR = 8'h08;
  localparam logic [7:0] A_CMD_DATA = 8'h0c;
  localparam logic [7:0] A_RD_DATA = 8'h10;
  localparam logic [7:0] A_STN_LOW = 8'h14;
  localparam logic [7:0] A_STN_HIGH = 8'h18;
  localparam logic [7:0] A_CFG_INFO = 8'h1c;
  localparam logic [7:0] A_WAKE_LANG = 8'h20;
  localparam logic [7:0] A_IMG_ADDR = 8'h24;
  localparam logic [7:0] A_IMG_DATA = 8'h28;
  localparam logic [7:0] A_DESC_HDR = 8'h2c;
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP = 1;
  localparam int CTRL_RELOAD = 3;

endpackage : ecl_pkg

// [rtl/ecl_image_ram.sv]
// Image memory holding the interpreted bytes of the serial configuration memory
`timescale 1ns/1ps
module ecl_image_ram (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wrEn,
  input wire logic [ecl_pkg::IMG_AW-1:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [ecl_pkg::IMG_AW-1:0] rdAddr,
  output logic [7:0] rdData
);
  import ecl_pkg::*;

  typedef struct packed {
    logic [(1<<IMG_AW)-1:0][7:0] mem;
    logic [7:0] rd;
  } ecl_ram_t;

  ecl_ram_t ram_reg;
  ecl_ram_t ram_next;

  // ==========================================================================
  // Storage: one write port, registered read port
  always_comb begin
    ram_next = ram_reg;
    if (wrEn) begin
      ram_next.mem[wrAddr] = wrData;
    end
    ram_next.rd = ram_reg.mem[rdAddr];
  end

  // Cleared at reset so a missing memory reads back as zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ram_reg <= '0;
    end else begin
      ram_reg <= ram_next;
    end
  end

  assign rdData = ram_reg.rd;

endmodule : ecl_image_ram

// [rtl/ecl_loader.sv]
// Serial configuration memory loader with APB register access
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
module ecl_loader #(
  parameter int unsigned POLL_CYCLES = ecl_pkg::POLL_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic eeCs,
  output logic eeSk,
  output logic eeDi,
  input wire logic eeDo,
  input wire logic remoteWakeStrap,
  input wire logic powerSourceStrap,
  output logic usbHoldOff,
  output logic loadDone,
  output logic eepromValid,
  output logic [47:0] stationAddr,
  output logic [7:0] fsPollInterval,
  output logic [7:0] hsPollInterval,
  output logic [1:0] txBoostField,
  output logic indicatorSelectBit,
  output logic remoteWakeEnable,
  output logic selfPowered,
  output logic [15:0] languageId,
  output logic languageIdValid,
  output logic [10:0] pinWakeEnableField,
  output logic [7:0] pmeFlags
);
  import ecl_pkg::*;

  typedef enum logic [2:0] {stIdle, stLow, stHigh, stGap, stPoll} ecl_state_t;
  typedef enum logic [1:0] {jobLoad, jobAttr, jobHost} ecl_job_t;

  typedef struct packed {
    ecl_state_t st;
    ecl_job_t job;
    logic loadPending;
    logic [3:0] skCnt;
    logic cs;
    logic sk;
    logic di;
    logic [4:0] bitCnt;
    logic [4:0] bitsTotal;
    logic [CMD_W-1:0] shOut;
    logic [7:0] shIn;
    logic [5:0] loadAddr;
    logic [19:0] pollCnt;
    logic [1:0] hostOp;
    logic [8:0] cmdAddr;
    logic [7:0] cmdData;
    logic [7:0] rdData;
    logic timeout;
    logic loadDone;
    logic valid;
    logic strAny;
    logic [7:0] hsCfgLen;
    logic [7:0] hsCfgOff;
    logic [7:0] attr;
    logic attrValid;
    logic [47:0] mac;
    logic [7:0] fsInt;
    logic [7:0] hsInt;
    logic [7:0] flags;
    logic [15:0] langId;
    logic [10:0] pinWake;
    logic [7:0] pme;
    logic [5:0] imgAddr;
    logic remoteWake;
    logic selfPow;
    logic [31:0] rdBus;
    logic [1:0] doSync;
    logic [1:0] rwkSync;
    logic [1:0] pwrSync;
  } ecl_regs_t;

  ecl_regs_t r_reg;
  ecl_regs_t r_next;
  logic ramWe;
  logic [7:0] ramRd;
  logic [31:0] rdMux;
  logic mapped;

  // ==========================================================================
  // Image memory: keeps the interpreted header bytes for software inspection
  ecl_image_ram u_image (
    .clk(clk),
    .arst_n(arst_n),
    .wrEn(ramWe),
    .wrAddr(r_reg.loadAddr),
    .wrData(r_reg.shIn),
    .rdAddr(r_reg.imgAddr),
    .rdData(ramRd)
  );

  // ==========================================================================
  // Register read decode
  always_comb begin
    rdMux = '0;
    mapped = 1'b1;
    unique case (paddr)
      A_CTRL: rdMux = {28'h0, 1'b0, r_reg.hostOp, 1'b0};
      A_STATUS: rdMux = {26'h0, r_reg.timeout, r_reg.attrValid, languageIdValid,
                         r_reg.valid, r_reg.loadDone, (r_reg.st != stIdle) | r_reg.loadPending};
      A_CMD_ADDR: rdMux = {23'h0, r_reg.cmdAddr};
      A_CMD_DATA: rdMux = {24'h0, r_reg.cmdData};
      A_RD_DATA: rdMux = {24'h0, r_reg.rdData};
      A_STN_LOW: rdMux = r_reg.mac[31:0];
      A_STN_HIGH: rdMux = {16'h0, r_reg.mac[47:32]};
      A_CFG_INFO: rdMux = {r_reg.pme, r_reg.flags, r_reg.hsInt, r_reg.fsInt};
      A_WAKE_LANG: rdMux = {r_reg.langId, 5'h0, r_reg.pinWake};
      A_IMG_ADDR: rdMux = {26'h0, r_reg.imgAddr};
      // Offset entries also show their byte address, length entries presence
      A_IMG_DATA: rdMux = {7'h0, {ramRd, 1'b0}, 7'h0, (ramRd != 8'h00), ramRd};
      A_DESC_HDR: rdMux = {8'h0, CFG_DESC_TYPE, DEV_DESC_SIZE, DEV_DESC_TYPE};
      default: begin
        rdMux = '0;
        mapped = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Next state: bus slave, serial engine and load sequencer
  always_comb begin
    logic finish;
    logic busWr;
    logic startRd;
    logic [8:0] rdAddr9;
    logic [2:0] macIdx;
    finish = 1'b0;
    startRd = 1'b0;
    rdAddr9 = '0;
    macIdx = '0;
    ramWe = 1'b0;
    r_next = r_reg;
    busWr = psel & penable & pwrite;

    // Pins from outside pass two flops before anything looks at them
    r_next.doSync = {r_reg.doSync[0], eeDo};
    r_next.rwkSync = {r_reg.rwkSync[0], remoteWakeStrap};
    r_next.pwrSync = {r_reg.pwrSync[0], powerSourceStrap};

    // Read data is captured in the setup phase, so the access phase answers at once
    if (psel && !penable && !pwrite) begin
      r_next.rdBus = rdMux;
    end

    // Register writes; a command is ignored while the engine is busy
    if (busWr) begin
      unique case (paddr)
        A_CTRL: begin
          if (r_reg.st == stIdle && !r_reg.loadPending) begin
            if (pwdata[CTRL_RELOAD]) begin
              r_next.loadPending = 1'b1;
            end else if (pwdata[CTRL_GO]) begin
              r_next.hostOp = pwdata[CTRL_OP +: 2];
              r_next.job = jobHost;
              r_next.timeout = 1'b0;
              r_next.st = stLow;
              r_next.cs = 1'b1;
              r_next.sk = 1'b0;
              r_next.skCnt = '0;
              r_next.bitCnt = '0;
              unique case (pwdata[CTRL_OP +: 2])
                HOP_READ: begin
                  r_next.shOut = {OPC_READ, r_reg.cmdAddr, 8'h00};
                  r_next.bitsTotal = BITS_LONG;
                end
                HOP_WRITE: begin
                  r_next.shOut = {OPC_WRITE, r_reg.cmdAddr, r_reg.cmdData};
                  r_next.bitsTotal = BITS_LONG;
                end
                HOP_ERASE: begin
                  r_next.shOut = {OPC_ERASE, r_reg.cmdAddr, 8'h00};
                  r_next.bitsTotal = BITS_SHORT;
                end
                HOP_EWEN: begin
                  r_next.shOut = {OPC_EWEN, EWEN_ADDR, 8'h00};
                  r_next.bitsTotal = BITS_SHORT;
                end
              endcase
              r_next.di = r_next.shOut[CMD_W-1];
            end
          end
        end
        A_CMD_ADDR: r_next.cmdAddr = pwdata[8:0];
        A_CMD_DATA: r_next.cmdData = pwdata[7:0];
        // Software may always set the station address, needed when the memory is invalid
        A_STN_LOW: r_next.mac[31:0] = pwdata;
        A_STN_HIGH: r_next.mac[47:32] = pwdata[15:0];
        A_IMG_ADDR: r_next.imgAddr = pwdata[5:0];
        default: ;
      endcase
    end

    // Serial engine: the clock pin is divided from clk, data sampled late in the high half
    unique case (r_reg.st)
      stIdle: begin
        if (r_reg.loadPending) begin
          r_next.loadPending = 1'b0;
          r_next.job = jobLoad;
          r_next.loadDone = 1'b0;
          r_next.valid = 1'b0;
          r_next.attrValid = 1'b0;
          r_next.strAny = 1'b0;
          r_next.hsCfgLen = '0;
          r_next.loadAddr = EA_SIG;
          startRd = 1'b1;
          rdAddr9 = '0;
        end
      end
      stLow: begin
        r_next.di = r_reg.shOut[CMD_W-1];
        r_next.skCnt = r_reg.skCnt + 4'h1;
        if (r_reg.skCnt == 4'(SK_HALF_CYC - 1)) begin
          r_next.skCnt = '0;
          r_next.sk = 1'b1;
          r_next.st = stHigh;
        end
      end
      stHigh: begin
        r_next.skCnt = r_reg.skCnt + 4'h1;
        if (r_reg.skCnt == 4'(SK_HALF_CYC - 1)) begin
          r_next.skCnt = '0;
          r_next.sk = 1'b0;
          r_next.shIn = {r_reg.shIn[6:0], r_reg.doSync[1]};
          r_next.shOut = {r_reg.shOut[CMD_W-2:0], 1'b0};
          r_next.bitCnt = r_reg.bitCnt + 5'h1;
          if (r_reg.bitCnt == r_reg.bitsTotal - 5'h1) begin
            r_next.cs = 1'b0;
            r_next.st = stGap;
          end else begin
            r_next.st = stLow;
          end
        end
      end
      stGap: begin
        r_next.skCnt = r_reg.skCnt + 4'h1;
        if (r_reg.skCnt == 4'(SK_HALF_CYC - 1)) begin
          r_next.skCnt = '0;
          if (r_reg.job == jobHost && (r_reg.hostOp == HOP_WRITE || r_reg.hostOp == HOP_ERASE)) begin
            // Reselect and wait for the memory to report its program cycle done
            r_next.cs = 1'b1;
            r_next.pollCnt = '0;
            r_next.st = stPoll;
          end else begin
            finish = 1'b1;
          end
        end
      end
      stPoll: begin
        r_next.pollCnt = r_reg.pollCnt + 20'h1;
        if (r_reg.doSync[1]) begin
          r_next.cs = 1'b0;
          finish = 1'b1;
        end else if (r_reg.pollCnt == 20'(POLL_CYCLES - 1)) begin
          r_next.cs = 1'b0;
          r_next.timeout = 1'b1;
          finish = 1'b1;
        end
      end
    endcase

    // Completion of one serial operation
    if (finish) begin
      r_next.st = stIdle;
      unique case (r_reg.job)
        jobHost: begin
          if (r_reg.hostOp == HOP_READ) begin
            r_next.rdData = r_reg.shIn;
          end
        end
        jobAttr: begin
          // A configuration descriptor overrides the wake and power flags and straps
          r_next.attr = r_reg.shIn;
          r_next.attrValid = 1'b1;
          r_next.loadDone = 1'b1;
        end
        jobLoad: begin
          ramWe = 1'b1;
          macIdx = 3'(r_reg.loadAddr - EA_MAC_FIRST);
          if (r_reg.loadAddr >= EA_MAC_FIRST && r_reg.loadAddr <= EA_MAC_LAST) begin
            r_next.mac[8*macIdx +: 8] = r_reg.shIn;
          end
          // Header fields are captured by address; the sequential read runs on to the PME byte
          unique case (r_reg.loadAddr)
            EA_FS: r_next.fsInt = r_reg.shIn;
            EA_HS: r_next.hsInt = r_reg.shIn;
            EA_FLAGS: r_next.flags = r_reg.shIn;
            EA_LANG_LO: r_next.langId[7:0] = r_reg.shIn;
            EA_LANG_HI: r_next.langId[15:8] = r_reg.shIn;
            EA_HS_CFG_LEN: r_next.hsCfgLen = r_reg.shIn;
            EA_HS_CFG_OFF: r_next.hsCfgOff = r_reg.shIn;
            EA_WAKE_LO: r_next.pinWake[7:0] = r_reg.shIn;
            EA_WAKE_HI: r_next.pinWake[10:8] = r_reg.shIn[2:0];
            EA_PME: r_next.pme = r_reg.shIn;
            default: ;
          endcase
          // Any nonzero string length makes the language identifier offered
          if (r_reg.loadAddr >= EA_STR_FIRST && r_reg.loadAddr <= EA_STR_LAST && !r_reg.loadAddr[0]) begin
            r_next.strAny = r_reg.strAny | (r_reg.shIn != 8'h00);
          end
          if (r_reg.loadAddr == EA_SIG && r_reg.shIn != SIG_VALID) begin
            r_next.loadDone = 1'b1;
          end else if (r_reg.loadAddr == EA_PME) begin
            if (r_reg.hsCfgLen != 8'h00) begin
              // Word offset doubled to a byte address, then the attributes byte
              r_next.job = jobAttr;
              startRd = 1'b1;
              rdAddr9 = {r_reg.hsCfgOff, 1'b0} + ATTR_OFS;
            end else begin
              r_next.loadDone = 1'b1;
            end
          end else begin
            if (r_reg.loadAddr == EA_SIG) begin
              r_next.valid = 1'b1;
            end
            r_next.loadAddr = r_reg.loadAddr + 6'h01;
            startRd = 1'b1;
            rdAddr9 = {3'h0, r_reg.loadAddr + 6'h01};
          end
        end
        default: ;
      endcase
    end

    // Launch a read of one byte
    if (startRd) begin
      r_next.shOut = {OPC_READ, rdAddr9, 8'h00};
      r_next.bitsTotal = BITS_LONG;
      r_next.bitCnt = '0;
      r_next.skCnt = '0;
      r_next.cs = 1'b1;
      r_next.sk = 1'b0;
      r_next.di = OPC_READ[2];
      r_next.st = stLow;
    end

    // Effective wake and power attributes: descriptor, then flags, then straps
    if (r_reg.attrValid) begin
      r_next.remoteWake = r_reg.attr[ATTR_RWK];
      r_next.selfPow = r_reg.attr[ATTR_SELF];
    end else if (r_reg.valid && r_reg.loadDone) begin
      r_next.remoteWake = r_reg.flags[FLG_RWK];
      r_next.selfPow = r_reg.flags[FLG_PWR];
    end else begin
      r_next.remoteWake = r_reg.rwkSync[1];
      r_next.selfPow = r_reg.pwrSync[1];
    end
  end

  // ==========================================================================
  // State register; the load starts by itself once reset releases
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
      r_reg.st <= stIdle;
      r_reg.job <= jobLoad;
      r_reg.loadPending <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata = r_reg.rdBus;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign eeCs = r_reg.cs;
  assign eeSk = r_reg.sk;
  assign eeDi = r_reg.di;
  assign usbHoldOff = ~r_reg.loadDone;
  assign loadDone = r_reg.loadDone;
  assign eepromValid = r_reg.valid;
  assign stationAddr = r_reg.mac;
  assign fsPollInterval = r_reg.fsInt;
  assign hsPollInterval = r_reg.hsInt;
  // Reserved flag bits 7:6 and 3 drive no output pin; they show only in the A_CFG_INFO register and in A_IMG_DATA at image entry 09h
  assign txBoostField = r_reg.flags[FLG_BOOST +: 2];
  assign indicatorSelectBit = r_reg.flags[FLG_LED];
  assign remoteWakeEnable = r_reg.remoteWake;
  assign selfPowered = r_reg.selfPow;
  assign languageId = r_reg.langId;
  assign languageIdValid = r_reg.valid & r_reg.loadDone & r_reg.strAny;
  assign pinWakeEnableField = r_reg.pinWake;
  assign pmeFlags = r_reg.pme;

endmodule : ecl_loader

// [tb/ecl_rom_model.sv]
// Behavioural serial configuration memory: read, write and erase
`timescale 1ns/1ps
module ecl_rom_model (
  input wire logic eeCs,
  input wire logic eeSk,
  input wire logic eeDi,
  output logic eeDo
);
  import ecl_pkg::*;
  logic [7:0] mem [0:511];
  logic [11:0] cmd;
  logic [7:0] wrByte;
  logic busy;
  int n;
  initial begin
    eeDo = 1'h0;
    busy = 1'h0;
    n = 0;
  end
  // ==========================================================================
  // Select
  // Line has no pull: a released output shows the inverse of its last level
  always @(negedge eeCs) begin
    n = 0;
    eeDo = ~eeDo;
  end
  // Ready answer comes late after a program cycle so the poll loop waits
  always @(posedge eeCs) begin
    eeDo = 1'h0;
    if (busy) #3000;
    busy = 1'h0;
    eeDo = 1'h1;
  end
  // ==========================================================================
  // Shift: start, opcode, 9 address bits, then 8 data bits MSB first
  always @(posedge eeSk) begin
    if (eeCs) begin
      n = n + 1;
      if (n <= 12) cmd = {cmd[10:0], eeDi};
      else if (n <= 20) wrByte = {wrByte[6:0], eeDi};
      if (n >= 13 && n <= 20 && cmd[11:9] == OPC_READ) eeDo = mem[cmd[8:0]][20-n];
      if (n == 12 && cmd[11:9] == OPC_ERASE) begin
        mem[cmd[8:0]] = 8'hff;
        busy = 1'h1;
      end
      if (n == 20 && cmd[11:9] == OPC_WRITE) begin
        mem[cmd[8:0]] = wrByte;
        busy = 1'h1;
      end
    end
  end
endmodule : ecl_rom_model

// [tb/ecl_loader_checker.sv]
// Port-level checks of the configuration loader
`timescale 1ns/1ps
module ecl_loader_checker #(
  parameter int unsigned POLL_CYCLES = ecl_pkg::POLL_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic eeCs,
  input wire logic eeSk,
  input wire logic eeDi,
  input wire logic remoteWakeStrap,
  input wire logic powerSourceStrap,
  input wire logic usbHoldOff,
  input wire logic loadDone,
  input wire logic eepromValid,
  input wire logic languageIdValid,
  input wire logic remoteWakeEnable,
  input wire logic selfPowered
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================================
  // Load sequence and serial link
  a_hold_in_load:
    assert property (!loadDone |-> usbHoldOff) else $error("hold-off low while loading");
  a_hold_release:
    assert property ($rose(loadDone) |-> ##[0:1] !usbHoldOff) else $error("hold-off kept after load");
  a_load_moves:
    assert property (!loadDone && !eeCs |-> ##[1:10] (eeCs || loadDone)) else $error("load stalled");
  a_clock_high:
    assert property ($rose(eeSk) |-> eeSk [*4] ##1 !eeSk) else $error("serial clock high time wrong");
  a_data_steady:
    assert property (eeSk |-> $stable(eeDi)) else $error("serial data moved while clock high");
  a_lang_valid:
    assert property (languageIdValid |-> eepromValid && loadDone) else $error("language id without image");
  // ==========================================================================
  // Straps rule an invalid image; five steady samples cover the sync delay
  a_power_strap:
    assert property ((loadDone && !eepromValid && $stable(powerSourceStrap)) [*5] |->
      selfPowered == powerSourceStrap) else $error("power source ignores strap");
  a_wake_strap:
    assert property ((loadDone && !eepromValid && $stable(remoteWakeStrap)) [*5] |->
      remoteWakeEnable == remoteWakeStrap) else $error("remote wake ignores strap");
  c_valid_load: cover property ($rose(loadDone) && eepromValid);
  c_blank_load: cover property ($rose(loadDone) && !eepromValid);
  c_no_lang: cover property (loadDone && eepromValid && !languageIdValid);
endmodule : ecl_loader_checker
bind ecl_loader ecl_loader_checker #(.POLL_CYCLES(POLL_CYCLES)) ecl_loader_checker_i (
  .clk(clk), .arst_n(arst_n), .eeCs(eeCs), .eeSk(eeSk), .eeDi(eeDi),
  .remoteWakeStrap(remoteWakeStrap), .powerSourceStrap(powerSourceStrap),
  .usbHoldOff(usbHoldOff), .loadDone(loadDone), .eepromValid(eepromValid),
  .languageIdValid(languageIdValid), .remoteWakeEnable(remoteWakeEnable), .selfPowered(selfPowered));

// [tb/ecl_loader_tb.sv]
// Self-checking bench of the configuration loader
`timescale 1ns/1ps
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin errCount++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module ecl_loader_tb;
  import ecl_pkg::*;
  // Image bytes 00h..20h; descriptor lengths are 0, 10 or 18
  localparam logic [7:0] IMG [33] = '{8'ha5, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h04,
    8'h0b, 8'h27, 8'h09, 8'h04, 8'h0a, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h12, 8'h40, 8'h12, 8'h28, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55, 8'hfd, 8'h81};
  // Reads after a good load as {address, expected}; IMG_ADDR rows are writes
  localparam logic [39:0] ROWS [10] = '{{A_STN_LOW, 32'h44332211}, {A_STN_HIGH, 32'h00006655},
    {A_CFG_INFO, 32'h81270b04}, {A_WAKE_LANG, 32'h04090555}, {A_DESC_HDR, 32'h00021201},
    {A_STATUS, 32'h0000001e}, {A_IMG_ADDR, 32'h0000000d}, {A_IMG_DATA, 32'h00600130},
    {A_IMG_ADDR, 32'h0000000e}, {A_IMG_DATA, 32'h00000000}};
  logic clk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic rwStrap = 1'h1, psStrap = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, se, eeCs, eeSk, eeDi, eeDo, usbHoldOff, loadDone, eepromValid;
  logic languageIdValid, remoteWakeEnable, selfPowered, indicatorSelectBit;
  logic [1:0] txBoostField;
  logic [47:0] stationAddr;
  logic [15:0] languageId;
  logic [10:0] pinWakeEnableField;
  logic [7:0] fsPollInterval, hsPollInterval, pmeFlags;
  int errCount = 0, testsRun = 0, cyc = 0;
  ecl_loader #(.POLL_CYCLES(200)) ecl_loader_i (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .eeCs(eeCs), .eeSk(eeSk), .eeDi(eeDi), .eeDo(eeDo),
    .remoteWakeStrap(rwStrap), .powerSourceStrap(psStrap), .usbHoldOff(usbHoldOff),
    .loadDone(loadDone), .eepromValid(eepromValid), .stationAddr(stationAddr), .fsPollInterval(fsPollInterval),
    .hsPollInterval(hsPollInterval), .txBoostField(txBoostField), .indicatorSelectBit(indicatorSelectBit),
    .remoteWakeEnable(remoteWakeEnable), .selfPowered(selfPowered), .languageId(languageId),
    .languageIdValid(languageIdValid), .pinWakeEnableField(pinWakeEnableField), .pmeFlags(pmeFlags));
  ecl_rom_model ecl_rom_model_i (.eeCs(eeCs), .eeSk(eeSk), .eeDi(eeDi), .eeDo(eeDo));
  // ==========================================================================
  // Clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errCount++;
      completeRun();
    end
  end
  // ==========================================================================
  // Tasks
  task automatic completeRun();
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : completeRun
  // Image past 20h holds user data at 21h, the configuration attributes at 57h and a device descriptor at 80h
  task automatic setImage();
    for (int i = 0; i < 512; i++) ecl_rom_model_i.mem[i] = 8'h00;
    foreach (IMG[i]) ecl_rom_model_i.mem[i] = IMG[i];
    ecl_rom_model_i.mem[9'h057] = 8'h40;
    ecl_rom_model_i.mem[9'h021] = 8'hc3;
    // Device descriptor at 80h; its string indexes stay 00h
    ecl_rom_model_i.mem[9'h083] = 8'h02;
    ecl_rom_model_i.mem[9'h087] = 8'h40;
    ecl_rom_model_i.mem[9'h091] = 8'h01;
  endtask : setImage
  // One APB transfer; entered just after a rising edge, leaves one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    se = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  // Control write, then status polled until busy clears
  task automatic runOp(input logic [31:0] c);
    apb(1'h1, A_CTRL, c);
    do apb(1'h0, A_STATUS, 32'h0); while (rd[0] === 1'h1);
    repeat (4) @(posedge clk);
  endtask : runOp
  // ==========================================================================
  // Main sequence
  initial begin
    setImage();
    repeat (5) @(posedge clk);
    arst_n <= 1'h1;
    repeat (2) @(posedge clk);
    `CHK(usbHoldOff, 1'h1)
    while (loadDone !== 1'h1) @(posedge clk);
    repeat (4) @(posedge clk);
    foreach (ROWS[i]) begin
      apb(ROWS[i][39:32] == A_IMG_ADDR, ROWS[i][39:32], ROWS[i][31:0]);
      if (ROWS[i][39:32] != A_IMG_ADDR) `CHK(rd, ROWS[i][31:0])
    end
    `CHK({remoteWakeEnable, selfPowered, txBoostField, indicatorSelectBit}, 5'h0d)
    `CHK({stationAddr, fsPollInterval, hsPollInterval}, {48'h665544332211, 16'h040b})
    `CHK({languageId, pinWakeEnableField, pmeFlags}, {16'h0409, 11'h555, 8'h81})
    apb(1'h0, 8'h40, 32'h0);
    `CHK({se, rd}, 33'h100000000)
    $display("test load done");
    apb(1'h1, A_STN_LOW, 32'hcafe0123);
    ecl_rom_model_i.mem[0] = 8'h00;
    runOp(32'h8);
    apb(1'h0, A_STN_LOW, 32'h0);
    `CHK({rd, eepromValid, languageIdValid}, 34'h32bf8048c)
    `CHK({remoteWakeEnable, selfPowered}, 2'h2)
    psStrap <= 1'h1;
    repeat (6) @(posedge clk);
    `CHK(selfPowered, 1'h1)
    psStrap <= 1'h0;
    $display("test invalid done");
    // Flags alone: no strings, no configuration descriptor
    setImage();
    ecl_rom_model_i.mem[9'h009] = 8'h23;
    ecl_rom_model_i.mem[9'h00c] = 8'h00;
    ecl_rom_model_i.mem[9'h018] = 8'h00;
    runOp(32'h8);
    `CHK({languageIdValid, remoteWakeEnable, selfPowered}, 3'h1)
    $display("test flags done");
    apb(1'h1, A_CMD_ADDR, 32'h22);
    apb(1'h1, A_CMD_DATA, 32'h5a);
    runOp(32'h3);
    for (int i = 0; i < 2; i++) begin
      apb(1'h1, A_CMD_ADDR, 32'h21 + i);
      runOp(32'h1);
      apb(1'h0, A_RD_DATA, 32'h0);
      `CHK(rd[7:0], (i == 0) ? 8'hc3 : 8'h5a)
    end
    runOp(32'h5);
    `CHK(rd[5:0], 6'h06)
    runOp(32'h7);
    runOp(32'h1);
    apb(1'h0, A_RD_DATA, 32'h0);
    `CHK(rd[7:0], 8'hff)
    $display("test host access done");
    apb(1'h1, A_CTRL, 32'h8);
    repeat (50) @(posedge clk);
    arst_n <= 1'h0;
    repeat (2) @(posedge clk);
    `CHK({usbHoldOff, loadDone}, 2'h2)
    arst_n <= 1'h1;
    while (loadDone !== 1'h1) @(posedge clk);
    `CHK(eepromValid, 1'h1)
    $display("test reset done");
    completeRun();
  end
endmodule : ecl_loader_tb
